/* File: tb/ioxp_i2c_master.sv */
// bus master model that clocks and drives the expander's serial bus
`timescale 1ns/100ps
module ioxp_i2c_master #(
	parameter int QTR = 45
) (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_pull
);
	// ----------------------------------------------------------------
	// bit level
	// ----------------------------------------------------------------
	// bus idles released; scl phases of two quarters stay above 4 link clocks
	initial
	begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	task automatic step();
		repeat (QTR) @(posedge clk);
	endtask

	// start and repeated start: sda falls while scl is high
	task automatic start();
		sda_pull <= 1'b0;
		step();
		scl <= 1'b1;
		step();
		sda_pull <= 1'b1;
		step();
		scl <= 1'b0;
		step();
	endtask

	// stop: sda rises while scl is high, line left released
	task automatic stop();
		sda_pull <= 1'b1;
		step();
		scl <= 1'b1;
		step();
		sda_pull <= 1'b0;
		step();
	endtask

	// data changes only while scl is low, sampled mid high phase
	task automatic bit_io(input logic b, output logic r);
		sda_pull <= ~b;
		step();
		scl <= 1'b1;
		step();
		r = sda;
		step();
		scl <= 1'b0;
		step();
	endtask

	// ----------------------------------------------------------------
	// byte level
	// ----------------------------------------------------------------
	// msb first, then the slave's acknowledge slot
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask

	// a cleared mack leaves the slot released to end the read
	task automatic rd_byte(input logic mack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(~mack, r);
	endtask
endmodule

/* File: tb/tb_i2c_gpio_expander_access.sv */
// self-checking bench of the i2c i/o expander access block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
	err_total++; $display("[FAIL] %s exp %h got %h", nm, (e), (g)); end end
module tb_i2c_gpio_expander_access;
	logic core_clk, link_clk, sys_rst, scl, m_pull, sda, sda_o, sda_oe;
	logic int_n_o, int_n_oe, ack;
	logic [2:0] sel;
	logic [7:0] rb;
	logic [15:0] ext_q, gpio_i, gpio_o, gpio_oe, hs, ls;
	logic [7:0] rg [8];
	logic [31:0] seed = 32'ha2d5;
	int ptr, err_total, n_checks;

	// ----------------------------------------------------------------
	// clocks, pins and instances
	// ----------------------------------------------------------------
	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	// link clock offset by 37 ns so its edges fall between core clock edges
	initial
	begin
		link_clk = 1'b0;
		#37;
		forever #80 link_clk = ~link_clk;
	end
	// a pin shows what the expander drives, else the outside level
	assign gpio_i = (gpio_oe & gpio_o) | (~gpio_oe & ext_q);
	assign sda = ~m_pull & (sda_oe ? sda_o : 1'b1); // pull-up when free

	ioxp_top ioxp_top_i (.core_clk(core_clk), .sys_rst(sys_rst),
		.link_clk(link_clk), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
		.sda_oe(sda_oe), .addr_sel(sel), .int_n_o(int_n_o),
		.int_n_oe(int_n_oe), .gpio_i(gpio_i), .gpio_o(gpio_o),
		.gpio_oe(gpio_oe), .high_side_driver(hs), .low_side_driver(ls));
	ioxp_i2c_master ioxp_i2c_master_i (.clk(core_clk), .sda(sda),
		.scl(scl), .sda_pull(m_pull));

	// ----------------------------------------------------------------
	// model and tasks
	// ----------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// input register: pin level xor polarity, live at the read
	function automatic logic [7:0] in_val(int p);
		logic [15:0] dir, pin;
		dir = {rg[7], rg[6]};
		pin = (~dir & {rg[3], rg[2]}) | (dir & ext_q);
		return pin[8*p +: 8] ^ rg[4+p];
	endfunction

	task automatic chk_pins();
		logic [15:0] dir, out;
		dir = {rg[7], rg[6]};
		out = {rg[3], rg[2]};
		repeat (80) @(posedge core_clk);
		`CHK("pin enable", ~dir, gpio_oe)
		`CHK("high side", ~dir & out, hs)
		`CHK("low side", ~dir & ~out, ls)
		`CHK("pin value", out, gpio_o)
		`CHK("open drain low", 2'b00, {sda_o, int_n_o})
	endtask

	task automatic open_cmd(logic [7:0] cmd);
		ioxp_i2c_master_i.start();
		ioxp_i2c_master_i.wr_byte({4'h4, sel, 1'b0}, ack);
		`CHK("addr ack", 1'b1, ack)
		ioxp_i2c_master_i.wr_byte(cmd, ack);
		`CHK("cmd ack", 1'b1, ack)
		ptr = cmd[2:0];
	endtask

	// random bytes, forced by or and and masks where a layout is needed
	task automatic wr_regs(logic [7:0] cmd, int n, logic [7:0] om,
		logic [7:0] am);
		logic [7:0] d;
		open_cmd(cmd);
		for (int i = 0; i < n; i++)
		begin
			d = (8'(rnd()) | om) & am;
			ioxp_i2c_master_i.wr_byte(d, ack);
			`CHK("data ack", 1'b1, ack)
			if (ptr > 1)
				rg[ptr] = d;
			ptr ^= 1;
		end
		ioxp_i2c_master_i.stop();
		chk_pins();
	endtask

	task automatic rd_regs(logic [7:0] cmd, int n);
		open_cmd(cmd);
		ioxp_i2c_master_i.start();
		ioxp_i2c_master_i.wr_byte({4'h4, sel, 1'b1}, ack);
		`CHK("read addr ack", 1'b1, ack)
		for (int i = 0; i < n; i++)
		begin
			ioxp_i2c_master_i.rd_byte(i < n - 1, rb);
			`CHK("read byte", (ptr < 2) ? in_val(ptr) : rg[ptr], rb)
			ptr ^= 1;
		end
		ioxp_i2c_master_i.stop();
	endtask

	task automatic wait_int(logic e);
		for (int i = 0; i < 400 && int_n_oe !== e; i++)
			@(posedge core_clk);
		`CHK("interrupt", e, int_n_oe)
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial
	begin
		sys_rst = 1'b1;
		sel = 3'h5;
		ext_q = 16'(rnd());
		err_total = 0;
		n_checks = 0;
		rg = '{8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'hff};
		repeat (20) @(posedge link_clk);
		@(posedge core_clk);
		sys_rst <= 1'b0;
		repeat (100) @(posedge core_clk);
		chk_pins();
		`CHK("reset interrupt", 1'b0, int_n_oe)
		// a foreign select code gets no acknowledge
		ioxp_i2c_master_i.start();
		ioxp_i2c_master_i.wr_byte({4'h4, sel ^ 3'h2, 1'b0}, ack);
		`CHK("foreign ack", 1'b0, ack)
		ioxp_i2c_master_i.stop();
		wr_regs(8'h03, 2, 8'h00, 8'hff);
		wr_regs(8'h05, 2, 8'h00, 8'hff);
		// pins 0 and 8 stay inputs, pins 1 and 9 become outputs
		wr_regs(8'h07, 3, 8'h01, 8'hfd);
		wr_regs(8'h00, 1, 8'h00, 8'hff);
		rd_regs(8'h03, 2);
		rd_regs(8'h05, 2);
		rd_regs(8'h07, 2);
		// stop inside a byte keeps only the acknowledged byte
		open_cmd(8'h02);
		rb = 8'(rnd());
		ioxp_i2c_master_i.wr_byte(rb, ack);
		rg[2] = rb;
		for (int i = 0; i < 4; i++)
			ioxp_i2c_master_i.bit_io(~rb[i], ack);
		ioxp_i2c_master_i.stop();
		chk_pins();
		// reads reload both change latches after the direction switch
		rd_regs(8'h00, 1);
		rd_regs(8'h01, 1);
		wait_int(1'b0);
		ext_q[8] <= ~ext_q[8];
		wait_int(1'b1);
		rd_regs(8'h00, 1);
		`CHK("other port read", 1'b1, int_n_oe)
		rd_regs(8'h01, 2);
		wait_int(1'b0);
		ext_q[0] <= ~ext_q[0];
		wait_int(1'b1);
		ext_q[0] <= ~ext_q[0];
		wait_int(1'b0);
		ext_q[9] <= ~ext_q[9];
		// flip output pin 9 through its register; no interrupt may follow
		wr_regs(8'h03, 1, 8'h02 & ~rg[3], ~(8'h02 & rg[3]));
		repeat (400) @(posedge core_clk);
		`CHK("output pin change", 1'b0, int_n_oe)
		stop_test();
	end

	// the sequence needs about 98000 cycles; a hang stops well after
	initial
	begin
		repeat (120000) @(posedge core_clk);
		err_total++;
		stop_test();
	end
endmodule

/* File: verilog/ioxp_pkg.sv */
// shared constants and types of the i2c i/o expander access block
package ioxp_pkg;

	// ----------------------------------------------------------------
	// geometry
	// ----------------------------------------------------------------
	localparam int PORT_W = 8;
	localparam int NUM_PINS = 16;
	localparam int ASEL_W = 3;
	localparam logic [3:0] BIT_LAST = 4'h8;
	localparam logic [3:0] BIT_FIRST_TX = 4'h1;

	// ----------------------------------------------------------------
	// bus address: fixed upper bits, three select pins below them
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_HI = 4'h4;

	// ----------------------------------------------------------------
	// register pointer: bits 2:1 pick the pair, bit 0 the port
	// ----------------------------------------------------------------
	localparam logic [1:0] GRP_IN = 2'h0;
	localparam logic [1:0] GRP_OUT = 2'h1;
	localparam logic [1:0] GRP_POL = 2'h2;
	localparam logic [1:0] GRP_DIR = 2'h3;
	localparam logic [2:0] PTR_RST = 3'h0;
	localparam logic [2:0] PTR_SWAP = 3'h1;

	// ----------------------------------------------------------------
	// reset values, one byte per port, and the two port masks
	// ----------------------------------------------------------------
	localparam logic [7:0] OUT_RST = 8'hff;
	localparam logic [7:0] POL_RST = 8'h00;
	localparam logic [7:0] DIR_RST = 8'hff;
	localparam logic [15:0] PORT0_MASK = 16'h00ff;
	localparam logic [15:0] PORT1_MASK = 16'hff00;

	// ----------------------------------------------------------------
	// bus engine states and byte phases
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_RX = 5'h02,
		ST_RACK = 5'h04,
		ST_TX = 5'h08,
		ST_TACK = 5'h10
	} ioxp_state_t;

	typedef enum logic [2:0] {
		PH_ADDR = 3'h1,
		PH_CMD = 3'h2,
		PH_DATA = 3'h4
	} ioxp_phase_t;

endpackage

/* File: verilog/ioxp_sync2.sv */
// two flip-flop synchroniser for levels
`timescale 1ns/100ps
module ioxp_sync2 #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic [W-1:0] async_d,
	output logic [W-1:0] sync_q
);

	logic [W-1:0] meta_q;

	// first stage feeds only the second
	always_ff @(posedge clk)
	begin
		meta_q <= async_d;
		sync_q <= meta_q;
	end

endmodule

/* File: verilog/ioxp_top.sv */
// i2c slave register access, pin drivers and change interrupt
`timescale 1ns/100ps

// Behaviour
// (R1) input-direction pins have both drivers off, pin floats on pull-up
// (R2) output-direction pins turn on exactly one driver, picked by output bit
// (R3) write: address with r/w low, then command byte selecting register
// (R4) after each written byte the pointer moves to the pair partner
// (R5) any number of data bytes per write, each stored at pointer
// (R6) master reads via command write, repeated start, address with r/w high
// (R7) read returns selected register, captured at falling edge of ack clock
// (R8) each further read byte comes from the other register of the pair
// (R9) master ends a read by not acknowledging the last byte
// (R10) stop may end a transfer anywhere; last acknowledged data stays valid
// (R11) interrupt asserts when an input-direction pin changes level
// (R12) interrupt releases on return to old level or input register read
// (R13) pins set as outputs never cause an interrupt
// (R14) interrupt clearing is per port; reading one port spares other
// (R15) output-to-input switch may raise a spurious interrupt
// (R16) command byte is first after address, codes 0 to 7 as pointer
// (R17) direction bit one means input, zero output; resets to input
// (R18) polarity bit one inverts reported input bit; resets to zero
// (R19) acknowledge only fixed upper bits plus three select pins
// (R20) inputs synchronised; change judged against last latched value
module ioxp_top #(
	parameter int NUM_PINS = ioxp_pkg::NUM_PINS
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic link_clk,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire logic [ioxp_pkg::ASEL_W-1:0] addr_sel,
	output logic int_n_o,
	output logic int_n_oe,
	input wire logic [NUM_PINS-1:0] gpio_i,
	output logic [NUM_PINS-1:0] gpio_o,
	output logic [NUM_PINS-1:0] gpio_oe,
	output logic [NUM_PINS-1:0] high_side_driver,
	output logic [NUM_PINS-1:0] low_side_driver
);

	// ----------------------------------------------------------------
	// link domain: reset and pin synchronisers
	// ----------------------------------------------------------------
	logic link_rst;
	logic scl_s;
	logic sda_s;
	logic scl_d_q;
	logic sda_d_q;
	logic [NUM_PINS-1:0] pin_s;
	logic [ioxp_pkg::ASEL_W-1:0] asel_s;

	ioxp_sync2 #(.W(1)) u_rst_sync (
		.clk(link_clk),
		.async_d(sys_rst),
		.sync_q(link_rst)
	);

	ioxp_sync2 #(.W(2)) u_bus_sync (
		.clk(link_clk),
		.async_d({scl_i, sda_i}),
		.sync_q({scl_s, sda_s})
	);

	// pins are sampled before any change detection
	ioxp_sync2 #(.W(NUM_PINS)) u_pin_sync ( // R20
		.clk(link_clk),
		.async_d(gpio_i),
		.sync_q(pin_s)
	);

	ioxp_sync2 #(.W(ioxp_pkg::ASEL_W)) u_asel_sync (
		.clk(link_clk),
		.async_d(addr_sel),
		.sync_q(asel_s)
	);

	// delayed copies for edge and start/stop detection; idle bus is high
	always_ff @(posedge link_clk)
	begin
		if (link_rst)
		begin
			scl_d_q <= 1'b1;
			sda_d_q <= 1'b1;
		end
		else
		begin
			scl_d_q <= scl_s;
			sda_d_q <= sda_s;
		end
	end

	// ----------------------------------------------------------------
	// bus events and byte decode
	// ----------------------------------------------------------------
	ioxp_pkg::ioxp_state_t state_q;
	ioxp_pkg::ioxp_phase_t phase_q;
	logic [3:0] bit_cnt_q;
	logic [7:0] sr_q;
	logic rw_q;
	logic sda_oe_q;
	logic [2:0] ptr_q;
	logic [NUM_PINS-1:0] out_q;
	logic [NUM_PINS-1:0] pol_q;
	logic [NUM_PINS-1:0] dir_q;
	logic [NUM_PINS-1:0] lat_q;
	logic lat_vld_q;
	logic int_q;
	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;
	logic byte_done;
	logic addr_hit;
	logic tx_load;
	logic rd_in;
	logic [2:0] cmd_code;
	logic [7:0] rd_byte;

	assign scl_rise = scl_s & ~scl_d_q;
	assign scl_fall = ~scl_s & scl_d_q;
	assign start_ev = scl_s & scl_d_q & sda_d_q & ~sda_s;
	assign stop_ev = scl_s & scl_d_q & ~sda_d_q & sda_s;
	assign byte_done = (state_q == ioxp_pkg::ST_RX) && scl_fall
		&& (bit_cnt_q == ioxp_pkg::BIT_LAST);
	assign addr_hit = (sr_q[7:1] == {ioxp_pkg::ADDR_HI, asel_s}); // R19
	assign cmd_code = sr_q[2:0];
	// byte for the master is taken at the falling edge closing the read address ack or a master ack
	assign tx_load = scl_fall && (((state_q == ioxp_pkg::ST_RACK)
		&& (phase_q == ioxp_pkg::PH_ADDR) && rw_q)
		|| (state_q == ioxp_pkg::ST_TACK)); // R7
	assign rd_in = tx_load && (ptr_q[2:1] == ioxp_pkg::GRP_IN);

	// register read mux; input pair shows pins through polarity
	always_comb
	begin
		case (ptr_q[2:1])
			ioxp_pkg::GRP_IN:
				rd_byte = sel_byte(pin_s ^ pol_q, ptr_q[0]); // R18
			ioxp_pkg::GRP_OUT:
				rd_byte = sel_byte(out_q, ptr_q[0]);
			ioxp_pkg::GRP_POL:
				rd_byte = sel_byte(pol_q, ptr_q[0]);
			default:
				rd_byte = sel_byte(dir_q, ptr_q[0]);
		endcase
	end

	function automatic logic [7:0] sel_byte(
		input logic [NUM_PINS-1:0] w,
		input logic port
	);
		sel_byte = port ? w[15:8] : w[7:0];
	endfunction

	// ----------------------------------------------------------------
	// bus engine
	// ----------------------------------------------------------------
	// stop wins over all but reset so a transfer can end at any bit
	always_ff @(posedge link_clk)
	begin
		if (link_rst)
		begin
			state_q <= ioxp_pkg::ST_IDLE;
			phase_q <= ioxp_pkg::PH_ADDR;
			bit_cnt_q <= '0;
			sr_q <= '0;
			rw_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end
		else if (stop_ev)
		begin
			state_q <= ioxp_pkg::ST_IDLE; // R10
			sda_oe_q <= 1'b0;
		end
		else if (start_ev)
		begin
			// a repeated start lands here too and re-reads the address
			state_q <= ioxp_pkg::ST_RX; // R6
			phase_q <= ioxp_pkg::PH_ADDR;
			bit_cnt_q <= '0;
			sda_oe_q <= 1'b0;
		end
		else
		begin
			case (state_q)
				ioxp_pkg::ST_RX:
				begin
					if (scl_rise)
					begin
						sr_q <= {sr_q[6:0], sda_s};
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end
					else if (byte_done)
					begin
						if ((phase_q == ioxp_pkg::PH_ADDR) && !addr_hit)
							state_q <= ioxp_pkg::ST_IDLE; // R19
						else
						begin
							state_q <= ioxp_pkg::ST_RACK;
							sda_oe_q <= 1'b1;
							if (phase_q == ioxp_pkg::PH_ADDR)
								rw_q <= sr_q[0]; // R3
						end
					end
				end
				ioxp_pkg::ST_RACK:
				begin
					if (tx_load)
					begin
						state_q <= ioxp_pkg::ST_TX; // R7
						sr_q <= rd_byte;
						sda_oe_q <= ~rd_byte[7];
						bit_cnt_q <= ioxp_pkg::BIT_FIRST_TX;
					end
					else if (scl_fall)
					begin
						state_q <= ioxp_pkg::ST_RX;
						sda_oe_q <= 1'b0;
						bit_cnt_q <= '0;
						if (phase_q == ioxp_pkg::PH_ADDR)
							phase_q <= ioxp_pkg::PH_CMD; // R16
						else
							phase_q <= ioxp_pkg::PH_DATA; // R5
					end
				end
				ioxp_pkg::ST_TX:
				begin
					if (scl_fall)
					begin
						if (bit_cnt_q == ioxp_pkg::BIT_LAST)
						begin
							state_q <= ioxp_pkg::ST_TACK;
							sda_oe_q <= 1'b0;
						end
						else
						begin
							sda_oe_q <= ~sr_q[6];
							sr_q <= {sr_q[6:0], 1'b0};
							bit_cnt_q <= bit_cnt_q + 4'h1;
						end
					end
				end
				ioxp_pkg::ST_TACK:
				begin
					// no ack from the master ends our transmission
					if (scl_rise && sda_s)
						state_q <= ioxp_pkg::ST_IDLE; // R9
					else if (tx_load)
					begin
						state_q <= ioxp_pkg::ST_TX; // R8
						sr_q <= rd_byte;
						sda_oe_q <= ~rd_byte[7];
						bit_cnt_q <= ioxp_pkg::BIT_FIRST_TX;
					end
				end
				default:
				begin
					state_q <= ioxp_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// register pointer
	// ----------------------------------------------------------------
	// only bit 0 flips, so the pointer leaves its pair only when a command byte loads it
	always_ff @(posedge link_clk)
	begin
		if (link_rst)
			ptr_q <= ioxp_pkg::PTR_RST;
		else if (byte_done && (phase_q == ioxp_pkg::PH_CMD))
			ptr_q <= cmd_code; // R16
		else if (byte_done && (phase_q == ioxp_pkg::PH_DATA))
			ptr_q <= ptr_q ^ ioxp_pkg::PTR_SWAP; // R4
		else if ((state_q == ioxp_pkg::ST_TACK) && scl_rise && !sda_s)
			ptr_q <= ptr_q ^ ioxp_pkg::PTR_SWAP; // R8
	end

	// ----------------------------------------------------------------
	// writable registers
	// ----------------------------------------------------------------
	// bytes land only after a full byte, so a stop mid-byte keeps the
	// last acknowledged contents; writes to the input pair are dropped
	always_ff @(posedge link_clk)
	begin
		if (link_rst)
		begin
			out_q <= {2{ioxp_pkg::OUT_RST}};
			pol_q <= {2{ioxp_pkg::POL_RST}}; // R18
			dir_q <= {2{ioxp_pkg::DIR_RST}}; // R17
		end
		else if (byte_done && (phase_q == ioxp_pkg::PH_DATA))
		begin
			case (ptr_q[2:1]) // R5
				ioxp_pkg::GRP_OUT:
					if (ptr_q[0])
						out_q[15:8] <= sr_q;
					else
						out_q[7:0] <= sr_q;
				ioxp_pkg::GRP_POL:
					if (ptr_q[0])
						pol_q[15:8] <= sr_q;
					else
						pol_q[7:0] <= sr_q;
				ioxp_pkg::GRP_DIR:
					if (ptr_q[0])
						dir_q[15:8] <= sr_q;
					else
						dir_q[7:0] <= sr_q;
				default:
					out_q <= out_q;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// change interrupt
	// ----------------------------------------------------------------
	// the latch is loaded from the pins right after reset, then one port
	// at a time when that port's input register is sent to the master
	always_ff @(posedge link_clk)
	begin
		if (link_rst)
		begin
			lat_q <= '0;
			lat_vld_q <= 1'b0;
		end
		else if (!lat_vld_q)
		begin
			lat_q <= pin_s; // R20
			lat_vld_q <= 1'b1;
		end
		else if (rd_in)
		begin
			if (ptr_q[0])
				lat_q[15:8] <= pin_s[15:8]; // R14
			else
				lat_q[7:0] <= pin_s[7:0]; // R12
		end
	end

	// level, not sticky: a pin that goes back clears it by itself, and a
	// pin turned to input that differs from the latch raises it at once
	always_ff @(posedge link_clk)
	begin
		if (link_rst)
			int_q <= 1'b0;
		else
			int_q <= lat_vld_q && |((pin_s ^ lat_q) & dir_q); // R11 R13 R15
	end

	assign int_n_oe = int_q;
	assign int_n_o = 1'b0;
	assign sda_o = 1'b0;
	assign sda_oe = sda_oe_q;

	// ----------------------------------------------------------------
	// core domain: pin drivers
	// ----------------------------------------------------------------
	logic [NUM_PINS-1:0] out_c;
	logic [NUM_PINS-1:0] dir_c;

	ioxp_word_xfer #(
		.W(2 * NUM_PINS),
		.RST_VAL({{2{ioxp_pkg::OUT_RST}}, {2{ioxp_pkg::DIR_RST}}})
	) u_drv_xfer (
		.src_clk(link_clk),
		.src_rst(link_rst),
		.src_data({out_q, dir_q}),
		.dst_clk(core_clk),
		.dst_rst(sys_rst),
		.dst_data({out_c, dir_c})
	);

	genvar gi;
	generate
		for (gi = 0; gi < NUM_PINS; gi = gi + 1)
		begin : g_pin
			// one driver on for outputs, both off for inputs
			always_ff @(posedge core_clk)
			begin
				if (sys_rst)
				begin
					high_side_driver[gi] <= 1'b0;
					low_side_driver[gi] <= 1'b0;
					gpio_oe[gi] <= 1'b0;
					gpio_o[gi] <= 1'b1;
				end
				else
				begin
					high_side_driver[gi] <= ~dir_c[gi] & out_c[gi]; // R2
					low_side_driver[gi] <= ~dir_c[gi] & ~out_c[gi]; // R1
					gpio_oe[gi] <= ~dir_c[gi]; // R17
					gpio_o[gi] <= out_c[gi];
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	AST_DRV_OFF: assert property (@(posedge core_clk) // R1
		disable iff (sys_rst)
		1'b1 |=> ((high_side_driver | low_side_driver) & $past(dir_c)) == '0)
		else $error("driver on for an input pin");

	AST_DRV_ONE: assert property (@(posedge core_clk) // R2
		disable iff (sys_rst)
		1'b1 |=> (high_side_driver == (~$past(dir_c) & $past(out_c)))
		&& (low_side_driver == (~$past(dir_c) & ~$past(out_c))))
		else $error("output pin driver does not follow output bit");

	AST_CMD_PTR: assert property (@(posedge link_clk) // R16
		disable iff (link_rst)
		(byte_done && phase_q == ioxp_pkg::PH_CMD)
		|=> ptr_q == $past(cmd_code) ##1 phase_q != ioxp_pkg::PH_ADDR)
		else $error("command byte not taken as pointer");

	AST_WR_TOGGLE: assert property (@(posedge link_clk) // R4
		disable iff (link_rst)
		(byte_done && phase_q == ioxp_pkg::PH_DATA)
		|=> ptr_q == ($past(ptr_q) ^ ioxp_pkg::PTR_SWAP))
		else $error("pointer did not move to pair partner after write");

	AST_WR_STORE: assert property (@(posedge link_clk) // R5
		disable iff (link_rst)
		(byte_done && phase_q == ioxp_pkg::PH_DATA
		&& ptr_q == {ioxp_pkg::GRP_OUT, 1'b0})
		|=> out_q[7:0] == $past(sr_q))
		else $error("written byte not stored");

	AST_RD_TOGGLE: assert property (@(posedge link_clk) // R8
		disable iff (link_rst)
		(state_q == ioxp_pkg::ST_TACK && scl_rise && !sda_s)
		|=> ptr_q == ($past(ptr_q) ^ ioxp_pkg::PTR_SWAP))
		else $error("read pointer did not alternate");

	AST_POL_READ: assert property (@(posedge link_clk) // R18
		disable iff (link_rst)
		(tx_load && ptr_q == {ioxp_pkg::GRP_IN, 1'b0})
		|=> sr_q == 8'($past(pin_s) ^ $past(pol_q)))
		else $error("input byte not inverted by polarity");

	AST_STOP_IDLE: assert property (@(posedge link_clk) // R10
		disable iff (link_rst)
		stop_ev |=> state_q == ioxp_pkg::ST_IDLE && !sda_oe)
		else $error("stop did not end transfer");

	AST_ADDR_MISS: assert property (@(posedge link_clk) // R19
		disable iff (link_rst)
		(byte_done && phase_q == ioxp_pkg::PH_ADDR && !addr_hit)
		|=> state_q == ioxp_pkg::ST_IDLE && !sda_oe)
		else $error("foreign address acknowledged");

	AST_INT_SET: assert property (@(posedge link_clk) // R11
		disable iff (link_rst)
		(lat_vld_q && ((pin_s ^ lat_q) & dir_q) != '0) |=> int_n_oe)
		else $error("input change without interrupt");

	AST_INT_QUIET: assert property (@(posedge link_clk) // R13
		disable iff (link_rst)
		(((pin_s ^ lat_q) & dir_q) == '0) |=> !int_n_oe)
		else $error("interrupt without input change");

	AST_RD_CLEAR: assert property (@(posedge link_clk) // R14
		disable iff (link_rst)
		(lat_vld_q && rd_in && !ptr_q[0])
		|=> (((lat_q ^ $past(pin_s)) & ioxp_pkg::PORT0_MASK) == '0)
		&& (((lat_q ^ $past(lat_q)) & ioxp_pkg::PORT1_MASK) == '0))
		else $error("port read cleared wrong port");

	AST_RESET_DEF: assert property (@(posedge link_clk) // R17
		$fell(link_rst) |-> dir_q == {2{ioxp_pkg::DIR_RST}}
		&& pol_q == {2{ioxp_pkg::POL_RST}} && !int_n_oe)
		else $error("registers not at defaults after reset");

endmodule

/* File: verilog/ioxp_word_xfer.sv */
// toggle handshake that carries a word between two clock domains
`timescale 1ns/100ps
module ioxp_word_xfer #(
	parameter int W = 32,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic src_clk,
	input wire logic src_rst,
	input wire logic [W-1:0] src_data,
	input wire logic dst_clk,
	input wire logic dst_rst,
	output logic [W-1:0] dst_data
);

	logic [W-1:0] hold_q;
	logic req_q;
	logic ack_q;
	logic ack_s;
	logic req_s;

	ioxp_sync2 #(.W(1)) u_ack_sync (
		.clk(src_clk),
		.async_d(ack_q),
		.sync_q(ack_s)
	);

	ioxp_sync2 #(.W(1)) u_req_sync (
		.clk(dst_clk),
		.async_d(req_q),
		.sync_q(req_s)
	);

	// hold stays frozen while a request is open, so the far side can
	// sample it as a whole word without tearing
	always_ff @(posedge src_clk)
	begin
		if (src_rst)
		begin
			hold_q <= RST_VAL;
			req_q <= 1'b0;
		end
		else if ((ack_s == req_q) && (src_data != hold_q))
		begin
			hold_q <= src_data;
			req_q <= ~req_q;
		end
	end

	// destination takes the word once per request toggle
	always_ff @(posedge dst_clk)
	begin
		if (dst_rst)
		begin
			dst_data <= RST_VAL;
			ack_q <= 1'b0;
		end
		else if (req_s != ack_q)
		begin
			dst_data <= hold_q;
			ack_q <= req_s;
		end
	end

endmodule
